//--- include/dsp16_pkg.sv
// Package of constants and types for the dual-slope 16-bit PWM timer.
package dsp16_pkg;

	// ----------------------------------------------------------------
	// Register map (word aligned byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] DSP16_OFS_CTRL   = 8'h00;
	localparam logic [7:0] DSP16_OFS_CMP_A  = 8'h04;
	localparam logic [7:0] DSP16_OFS_CMP_B  = 8'h08;
	localparam logic [7:0] DSP16_OFS_CAPT   = 8'h0c;
	localparam logic [7:0] DSP16_OFS_COUNT  = 8'h10;
	localparam logic [7:0] DSP16_OFS_FLAGS  = 8'h14;
	localparam logic [7:0] DSP16_OFS_STATUS = 8'h18;

	// ----------------------------------------------------------------
	// Field positions of the control register
	// ----------------------------------------------------------------
	localparam int DSP16_CTL_WGM_LSB = 0;
	localparam int DSP16_CTL_COMA_LSB = 4;
	localparam int DSP16_CTL_COMB_LSB = 6;
	localparam int DSP16_CTL_PRE_LSB = 8;
	localparam int DSP16_CTL_DIRA_BIT = 11;
	localparam int DSP16_CTL_DIRB_BIT = 12;

	// Flag register bits: write one to clear.
	localparam int DSP16_FLG_OVF = 0;
	localparam int DSP16_FLG_CMPA = 1;
	localparam int DSP16_FLG_CMPB = 2;
	localparam int DSP16_FLG_CAPT = 3;

	// ----------------------------------------------------------------
	// Waveform modes and fixed tops
	// ----------------------------------------------------------------
	localparam logic [3:0] DSP16_WGM_PC8   = 4'h1;
	localparam logic [3:0] DSP16_WGM_PC9   = 4'h2;
	localparam logic [3:0] DSP16_WGM_PC10  = 4'h3;
	localparam logic [3:0] DSP16_WGM_PFC_C = 4'h8;
	localparam logic [3:0] DSP16_WGM_PFC_A = 4'h9;
	localparam logic [3:0] DSP16_WGM_PC_C  = 4'ha;
	localparam logic [3:0] DSP16_WGM_PC_A  = 4'hb;

	localparam logic [15:0] DSP16_TOP8  = 16'h00ff;
	localparam logic [15:0] DSP16_TOP9  = 16'h01ff;
	localparam logic [15:0] DSP16_TOP10 = 16'h03ff;
	localparam logic [15:0] DSP16_BOTTOM = 16'h0000;
	localparam logic [15:0] DSP16_ONE    = 16'h0001;

	// Compare output modes.
	localparam logic [1:0] DSP16_COM_OFF = 2'h0;
	localparam logic [1:0] DSP16_COM_TGL = 2'h1;
	localparam logic [1:0] DSP16_COM_NON = 2'h2;
	localparam logic [1:0] DSP16_COM_INV = 2'h3;

	// Prescaler selects and terminal counts (factor minus one).
	localparam logic [2:0] DSP16_PRE_STOP = 3'h0;
	localparam logic [2:0] DSP16_PRE_1    = 3'h1;
	localparam logic [2:0] DSP16_PRE_8    = 3'h2;
	localparam logic [2:0] DSP16_PRE_64   = 3'h3;
	localparam logic [2:0] DSP16_PRE_256  = 3'h4;
	localparam logic [2:0] DSP16_PRE_1024 = 3'h5;
	localparam logic [9:0] DSP16_DIV_1    = 10'h000;
	localparam logic [9:0] DSP16_DIV_8    = 10'h007;
	localparam logic [9:0] DSP16_DIV_64   = 10'h03f;
	localparam logic [9:0] DSP16_DIV_256  = 10'h0ff;
	localparam logic [9:0] DSP16_DIV_1024 = 10'h3ff;

	localparam logic [1:0] DSP16_HTRANS_NONSEQ = 2'h2;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [3:0] waveform_mode;
		logic [1:0] chan_a_output_mode;
		logic [1:0] chan_b_output_mode;
		logic [2:0] prescale_sel;
		logic       pin_direction_a;
		logic       pin_direction_b;
	} dsp16_ctrl_t;

	typedef struct packed {
		logic       wr_pend;
		logic [7:0] addr;
		logic [31:0] rdata;
		dsp16_ctrl_t ctrl;
		logic [15:0] cmp_buf_a;
		logic [15:0] cmp_buf_b;
		logic [15:0] cmp_a;
		logic [15:0] cmp_b;
		logic [15:0] capture_value_reg;
		logic [15:0] timer_count;
		logic        count_down;
		logic [9:0]  prescale_cnt;
		logic        chan_a_wave;
		logic        chan_b_wave;
		logic        chan_a_wave_out;
		logic        chan_a_wave_oe;
		logic        chan_b_wave_out;
		logic        chan_b_wave_oe;
		logic [3:0]  flags;
	} dsp16_state_t;

endpackage

//--- rtl/dsp16_timer.sv
// Dual-slope 16-bit PWM timer with AHB-Lite register slave.
//
// Behaviour
// R1 - Modes 1, 2, 3, 10, 11 count bottom to top and back, repeatedly.
// R2 - Phase correct top: 0x00FF, 0x01FF, 0x03FF, capture value, or compare A.
// R3 - Counter stays at top one tick, then counts down.
// R4 - Mode two clears on up-match, sets on down-match; mode three inverts.
// R5 - Software keeps register top between 0x0003 and 0xFFFF.
// R6 - Any compare match sets that channel's compare flag.
// R7 - Phase correct sets the overflow flag on reaching bottom.
// R8 - Phase correct loads compares at top; top register flag set that tick.
// R9 - With fixed top, compare writes clear bits above the resolution.
// R10 - Compare at bottom gives constant low, at top constant high.
// R11 - Mode 11 with channel A mode 1 toggles channel A each match.
// R12 - Modes 8 and 9: frequency correct, top from capture or compare A.
// R13 - Frequency correct loads compares at bottom, sets overflow flag then.
// R14 - Frequency correct sets top register flag when counter reaches top.
// R15 - Mode 9 with channel A mode 1 toggles channel A each match.
// R16 - Software keeps top at or above all compares, else no match.
// R17 - Waveform reaches the pin only when its direction bit selects output.
// R18 - Software prefers frequency correct mode when changing top while running.
// R19 - Counter advances once per prescaled tick: 1, 8, 64, 256, 1024.
// R20 - Mode 0 disconnects; mode 1 toggles A only in 9/11; B disconnected.
// R21 - Count, direction and outputs change only on ticks; reset zero, upward. Here bus writes also change the count and the pin enables.
//
// Register map, one word per register, data in the low bits:
// 0x00 control: [3:0] waveform mode, [5:4] channel A output mode,
//      [7:6] channel B output mode, [10:8] prescale select,
//      [11] pin direction A, [12] pin direction B.
// 0x04 channel A compare buffer; 0x08 channel B compare buffer.
// 0x0c capture value, which sets top in modes 8 and 10.
// 0x10 timer count, writable; a tick in the same cycle wins.
// 0x14 flags, write one to clear; an event in the same cycle wins.
//      [0] overflow, [1] compare A, [2] compare B, [3] capture.
// 0x18 status: [0] channel A waveform, [1] counting down.
// Unmapped reads return zero and unmapped writes are dropped. The slave
// never inserts a wait state and always answers OKAY, so a master may
// issue transfers back to back.
//
// The implementer's own choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps

module dsp16_timer
	import dsp16_pkg::*;
(
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Waveform pins
	output logic             chan_a_wave_out,
	output logic             chan_a_wave_oe,
	output logic             chan_b_wave_out,
	output logic             chan_b_wave_oe
);

	dsp16_state_t s_q;
	dsp16_state_t s_d;

	// ----------------------------------------------------------------
	// Combinational helpers
	// ----------------------------------------------------------------
	logic        tick;
	logic [9:0]  div_end;
	logic        pc_mode;
	logic        pfc_mode;
	logic        run;
	logic        fixed_top;
	logic [15:0] fixed_mask;
	logic [15:0] top;
	logic        at_top;
	logic        at_bottom;
	logic        match_a;
	logic        match_b;
	logic        top_is_a;
	logic        top_is_c;
	logic        a_toggle_ok;
	logic        lvl_match;
	logic [31:0] ctrl_word;
	logic [3:0]  clr;

	// Codes 6 and 7 decode to the shortest count here, but the tick below
	// is held off for them, so they stop the timer just as code zero does.
	always_comb begin
		unique case (s_q.ctrl.prescale_sel)
			DSP16_PRE_8:    div_end = DSP16_DIV_8;
			DSP16_PRE_64:   div_end = DSP16_DIV_64;
			DSP16_PRE_256:  div_end = DSP16_DIV_256;
			DSP16_PRE_1024: div_end = DSP16_DIV_1024;
			default:        div_end = DSP16_DIV_1;
		endcase
	end

	// Tick when the prescaler reaches its terminal count. With a divide of
	// one the tick is high every cycle, which is the fastest timer rate.
	assign tick = (s_q.ctrl.prescale_sel != DSP16_PRE_STOP) && (s_q.ctrl.prescale_sel <= DSP16_PRE_1024)
		&& (s_q.prescale_cnt == div_end); // R19

	always_comb begin
		pc_mode = 1'b0;
		pfc_mode = 1'b0;
		fixed_top = 1'b0;
		fixed_mask = 16'hffff;
		top = s_q.capture_value_reg;
		top_is_a = 1'b0;
		top_is_c = 1'b0;
		unique case (s_q.ctrl.waveform_mode)
			DSP16_WGM_PC8: begin
				pc_mode = 1'b1;
				fixed_top = 1'b1;
				fixed_mask = DSP16_TOP8;
			end
			DSP16_WGM_PC9: begin
				pc_mode = 1'b1;
				fixed_top = 1'b1;
				fixed_mask = DSP16_TOP9;
			end
			DSP16_WGM_PC10: begin
				pc_mode = 1'b1;
				fixed_top = 1'b1;
				fixed_mask = DSP16_TOP10;
			end
			DSP16_WGM_PC_C: begin
				pc_mode = 1'b1;
				top_is_c = 1'b1;
			end
			DSP16_WGM_PC_A: begin
				pc_mode = 1'b1;
				top_is_a = 1'b1;
			end
			DSP16_WGM_PFC_C: begin
				pfc_mode = 1'b1;
				top_is_c = 1'b1;
			end // R12
			DSP16_WGM_PFC_A: begin
				pfc_mode = 1'b1;
				top_is_a = 1'b1;
			end // R12
			default: begin
			end
		endcase
		if (fixed_top) begin
			top = fixed_mask; // R2
		end else if (top_is_a) begin
			top = s_q.cmp_a; // R2
		end
	end

	assign run = pc_mode | pfc_mode;
	assign at_top = (s_q.timer_count == top);
	assign at_bottom = (s_q.timer_count == DSP16_BOTTOM);
	// A compare above top never equals the count, so it never matches.
	assign match_a = (s_q.timer_count == s_q.cmp_a); // R16
	assign match_b = (s_q.timer_count == s_q.cmp_b);
	// Toggling gives half duty only when compare A is top: then the pin
	// turns once per counter period. In every other mode it stays put.
	assign a_toggle_ok = (s_q.ctrl.waveform_mode == DSP16_WGM_PFC_A)
		|| (s_q.ctrl.waveform_mode == DSP16_WGM_PC_A); // R11 R15

	// Level a non-inverting channel takes at a match. Bottom is held for one
	// tick with the direction still down, so the turn at bottom must count as
	// up-counting, or a compare of zero would leave the pin high for good. The
	// turn at top likewise counts as down-counting.
	assign lvl_match = at_top | (s_q.count_down & ~at_bottom); // R4 R10

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		clr = '0;
		ctrl_word = '0;
		s_d.rdata = 32'h0000_0000;

		// Prescaler divider runs while a clock source is chosen.
		if (tick || s_q.ctrl.prescale_sel == DSP16_PRE_STOP) begin
			s_d.prescale_cnt = '0;
		end else begin
			s_d.prescale_cnt = s_q.prescale_cnt + 10'h001;
		end

		// Bus address phase. Read data is captured here and stands for the
		// data phase only; it falls back to zero, so no stale word lingers.
		s_d.wr_pend = 1'b0;
		if (hsel && hready && htrans == DSP16_HTRANS_NONSEQ) begin
			s_d.addr = haddr[7:0];
			s_d.wr_pend = hwrite;
			if (!hwrite) begin
				ctrl_word[DSP16_CTL_WGM_LSB +: 4] = s_q.ctrl.waveform_mode;
				ctrl_word[DSP16_CTL_COMA_LSB +: 2] = s_q.ctrl.chan_a_output_mode;
				ctrl_word[DSP16_CTL_COMB_LSB +: 2] = s_q.ctrl.chan_b_output_mode;
				ctrl_word[DSP16_CTL_PRE_LSB +: 3] = s_q.ctrl.prescale_sel;
				ctrl_word[DSP16_CTL_DIRA_BIT] = s_q.ctrl.pin_direction_a;
				ctrl_word[DSP16_CTL_DIRB_BIT] = s_q.ctrl.pin_direction_b;
				unique case (haddr[7:0])
					DSP16_OFS_CTRL:   s_d.rdata = ctrl_word;
					DSP16_OFS_CMP_A:  s_d.rdata = {16'h0000, s_q.cmp_buf_a};
					DSP16_OFS_CMP_B:  s_d.rdata = {16'h0000, s_q.cmp_buf_b};
					DSP16_OFS_CAPT:   s_d.rdata = {16'h0000, s_q.capture_value_reg};
					DSP16_OFS_COUNT:  s_d.rdata = {16'h0000, s_q.timer_count};
					DSP16_OFS_FLAGS:  s_d.rdata = {28'h0000000, s_q.flags};
					DSP16_OFS_STATUS: s_d.rdata = {30'h00000000, s_q.count_down,
						s_q.chan_a_wave};
					default:          s_d.rdata = 32'h0000_0000;
				endcase
			end
		end

		// Bus data phase of a write.
		if (s_q.wr_pend) begin
			unique case (s_q.addr)
				DSP16_OFS_CTRL: begin
					s_d.ctrl.waveform_mode = hwdata[DSP16_CTL_WGM_LSB +: 4];
					s_d.ctrl.chan_a_output_mode = hwdata[DSP16_CTL_COMA_LSB +: 2];
					s_d.ctrl.chan_b_output_mode = hwdata[DSP16_CTL_COMB_LSB +: 2];
					s_d.ctrl.prescale_sel = hwdata[DSP16_CTL_PRE_LSB +: 3];
					s_d.ctrl.pin_direction_a = hwdata[DSP16_CTL_DIRA_BIT];
					s_d.ctrl.pin_direction_b = hwdata[DSP16_CTL_DIRB_BIT];
				end
				DSP16_OFS_CMP_A: s_d.cmp_buf_a = hwdata[15:0] & fixed_mask; // R9
				DSP16_OFS_CMP_B: s_d.cmp_buf_b = hwdata[15:0] & fixed_mask; // R9
				DSP16_OFS_CAPT:  s_d.capture_value_reg = hwdata[15:0];
				DSP16_OFS_COUNT: s_d.timer_count = hwdata[15:0];
				DSP16_OFS_FLAGS: clr = hwdata[3:0];
				default: begin
				end
			endcase
		end
		s_d.flags = s_q.flags & ~clr;

		// Counter, buffer loads, flags and waveforms; all gated by the tick.
		// A count written by the bus in the same cycle as a tick is lost here:
		// the tick wins, so software should stop the prescaler before writing.
		if (tick && run) begin // R21
			if (s_q.count_down) begin
				if (at_bottom) begin
					s_d.count_down = 1'b0;
					s_d.timer_count = DSP16_ONE;
				end else begin
					s_d.timer_count = s_q.timer_count - DSP16_ONE;
				end
			end else if (at_top) begin
				s_d.count_down = 1'b1; // R3
				s_d.timer_count = s_q.timer_count - DSP16_ONE;
			end else begin
				s_d.timer_count = s_q.timer_count + DSP16_ONE; // R1
			end

			if (at_bottom) begin
				s_d.flags[DSP16_FLG_OVF] = 1'b1; // R7 R13
			end
			if (at_top && top_is_a) begin
				s_d.flags[DSP16_FLG_CMPA] = 1'b1; // R8 R14
			end
			if (at_top && top_is_c) begin
				s_d.flags[DSP16_FLG_CAPT] = 1'b1; // R8 R14
			end
			if (match_a) begin
				s_d.flags[DSP16_FLG_CMPA] = 1'b1; // R6
			end
			if (match_b) begin
				s_d.flags[DSP16_FLG_CMPB] = 1'b1; // R6
			end
			// After reset the active compares are zero until the first load.
			// Phase correct loads at top, so the slopes on either side of a top
			// change differ; frequency correct loads at bottom and stays even.
			if ((pc_mode && at_top) || (pfc_mode && at_bottom)) begin
				s_d.cmp_a = s_q.cmp_buf_a; // R8 R13
				s_d.cmp_b = s_q.cmp_buf_b;
			end

			// Up-match clears, down-match sets. A compare equal to top thus
			// holds the pin high and one equal to bottom holds it low, in place
			// of a one-tick glitch per period; inverting gives the opposite.
			if (match_a) begin
				unique case (s_q.ctrl.chan_a_output_mode)
					DSP16_COM_NON: s_d.chan_a_wave = lvl_match; // R4 R10
					DSP16_COM_INV: s_d.chan_a_wave = ~lvl_match; // R4 R10
					DSP16_COM_TGL: begin
						if (a_toggle_ok) begin
							s_d.chan_a_wave = ~s_q.chan_a_wave; // R11 R15
						end
					end
					default: begin
					end
				endcase
			end
			if (match_b) begin
				unique case (s_q.ctrl.chan_b_output_mode)
					DSP16_COM_NON: s_d.chan_b_wave = lvl_match; // R4 R10
					DSP16_COM_INV: s_d.chan_b_wave = ~lvl_match; // R4 R10
					default: begin
					end
				endcase
			end
		end

		// Pin drivers: disconnected modes release the pin entirely.
		// The pin copies the next waveform, so pin and status bit move
		// together; a cleared direction bit releases the pin but the
		// waveform keeps running, so it reappears in phase.
		s_d.chan_a_wave_out = s_d.chan_a_wave;
		s_d.chan_b_wave_out = s_d.chan_b_wave;
		s_d.chan_a_wave_oe = s_d.ctrl.pin_direction_a
			&& (s_d.ctrl.chan_a_output_mode[1]
			|| (s_d.ctrl.chan_a_output_mode == DSP16_COM_TGL
			&& (s_d.ctrl.waveform_mode == DSP16_WGM_PFC_A
			|| s_d.ctrl.waveform_mode == DSP16_WGM_PC_A))); // R17 R20
		s_d.chan_b_wave_oe = s_d.ctrl.pin_direction_b
			&& s_d.ctrl.chan_b_output_mode[1]; // R17 R20
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	// All state, bus capture included, is one registered struct, so reset
	// clears everything in one place and nothing escapes it.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_q <= '0; // R21
		end else begin
			s_q <= s_d;
		end
	end

	// The bus never waits and never errors, so ready and response are fixed.
	assign hrdata = s_q.rdata;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign chan_a_wave_out = s_q.chan_a_wave_out;
	assign chan_a_wave_oe = s_q.chan_a_wave_oe;
	assign chan_b_wave_out = s_q.chan_b_wave_out;
	assign chan_b_wave_oe = s_q.chan_b_wave_oe;

endmodule

//--- verification/dsp16_load.sv
// External load seen on the two waveform pins.
`timescale 1ns/1ps
module dsp16_load (
	// Pins from the timer
	input  wire logic hclk,
	input  wire logic a_out,
	input  wire logic a_oe,
	input  wire logic b_out,
	input  wire logic b_oe,
	// Level on the wires
	output logic      a_lvl,
	output logic      b_lvl
);
	logic flip = 1'b0;
	// A released pin floats; a moving pattern keeps it from faking a steady level.
	always @(posedge hclk) flip <= ~flip;
	assign a_lvl = a_oe ? a_out : flip;
	assign b_lvl = b_oe ? b_out : flip;
endmodule

//--- verification/dsp16_timer_monitor.sv
// Port checker of the dual-slope PWM timer, bound to its top module.
`timescale 1ns/1ps
module dsp16_timer_monitor
	import dsp16_pkg::*;
(
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// Bus
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	input  wire logic        hreadyout,
	input  wire logic        hresp,
	// Pins
	input  wire logic        chan_a_wave_out,
	input  wire logic        chan_a_wave_oe,
	input  wire logic        chan_b_wave_out,
	input  wire logic        chan_b_wave_oe
);
	// ----
	// Shadow of the control register
	// ----
	logic        wr_q;
	logic [12:0] c_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= 1'b0;
			c_q  <= '0;
		end else begin
			wr_q <= hsel && hready && htrans == DSP16_HTRANS_NONSEQ && hwrite
				&& haddr[7:0] == DSP16_OFS_CTRL;
			if (wr_q)
				c_q <= hwdata[12:0];
		end
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// The output enable is registered, so the shadow one cycle back is allowed too.
	dir_a_gate_a: assert property (chan_a_wave_oe |-> c_q[11] || $past(c_q[11]))
		else $error("pin A driven with direction off");
	dir_b_gate_a: assert property (chan_b_wave_oe |-> c_q[12] || $past(c_q[12]))
		else $error("pin B driven with direction off");
	b_mode_gate_a: assert property (chan_b_wave_oe |-> c_q[7] || $past(c_q[7]))
		else $error("pin B driven outside modes two and three");
	a_toggle_gate_a: assert property (
		chan_a_wave_oe && c_q[5:4] == DSP16_COM_TGL && $past(c_q) == c_q
		&& $past(c_q, 2) == c_q |-> c_q[3:0] == DSP16_WGM_PFC_A || c_q[3:0] == DSP16_WGM_PC_A)
		else $error("pin A toggles in a mode without compare A top");
	a_off_a: assert property (
		c_q[5:4] == DSP16_COM_OFF && $past(c_q[5:4]) == DSP16_COM_OFF |-> !chan_a_wave_oe)
		else $error("pin A driven while disconnected");
	rst_quiet_a: assert property ($rose(hresetn) |-> !chan_a_wave_out && !chan_b_wave_out
		&& !chan_a_wave_oe && !chan_b_wave_oe)
		else $error("pins not at reset level");
	stop_hold_a: assert property (
		c_q[10:8] == DSP16_PRE_STOP && $past(c_q[10:8]) == DSP16_PRE_STOP
		|=> $stable(chan_a_wave_out) && $stable(chan_b_wave_out))
		else $error("waveform moved without timer ticks");
	bus_okay_a: assert property (hreadyout && !hresp)
		else $error("slave stalled or answered an error");
endmodule
bind dsp16_timer dsp16_timer_monitor u_mon (.hclk, .hresetn, .hsel, .haddr, .htrans,
	.hwrite, .hready, .hwdata, .hreadyout, .hresp, .chan_a_wave_out, .chan_a_wave_oe,
	.chan_b_wave_out, .chan_b_wave_oe);

//--- verification/tb.sv
// Self-checking bench of the dual-slope PWM timer.
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
	$display("mismatch t=%0t got %0h exp %0h", $time, g, e); end end
module tb
	import dsp16_pkg::*;
;
	logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = '0, hwdata = '0, hrdata, rd, ctl, ev;
	logic [31:0] seed = 32'hd6b14ea8;
	logic        hreadyout, hresp, a_out, a_oe, b_out, b_oe, a_lvl, b_lvl;
	int          mismatches = 0, cmp_count = 0;
	int          k, j, n, top, ca, cb, w, ha, hb, oa, ob;
	bit          atop, ctop;
	logic [3:0]  wgm [8] = '{4'h1, 4'h2, 4'h3, 4'ha, 4'hb, 4'h8, 4'h9, 4'h1};
	logic [2:0]  pre [8] = '{3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h2, 3'h1, 3'h1};

	initial forever #5 hclk = ~hclk;

	dsp16_timer DUT (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
		.hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .chan_a_wave_out(a_out),
		.chan_a_wave_oe(a_oe), .chan_b_wave_out(b_out), .chan_b_wave_oe(b_oe));
	dsp16_load u_load (.hclk, .a_out, .a_oe, .b_out, .b_oe, .a_lvl, .b_lvl);

	// ----
	// Tasks
	// ----
	task end_sim;
		if (mismatches == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task rdy;
		int i;
		for (i = 0; i < 50; i++) begin
			@(posedge hclk);
			if (hreadyout === 1'b1)
				break;
		end
		if (i == 50) begin
			mismatches++;
			end_sim();
		end
	endtask

	task bus(input logic w_r, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= DSP16_HTRANS_NONSEQ;
		haddr <= {24'h0, a};
		hwrite <= w_r;
		rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		rdy();
		rd = hrdata;
	endtask

	// Counts high levels and driven cycles, sampled mid-cycle where all is settled.
	task measure(input int cyc);
		ha = 0;
		hb = 0;
		oa = 0;
		ob = 0;
		repeat (cyc) begin
			@(negedge hclk);
			ha += (a_lvl === 1'b1);
			hb += (b_lvl === 1'b1);
			oa += (a_oe === 1'b1);
			ob += (b_oe === 1'b1);
		end
	endtask

	// ----
	// Main sequence
	// ----
	initial begin
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		for (k = 0; k < 8; k++) begin
			n = (pre[k] == DSP16_PRE_8) ? 8 : 1;
			seed = lfsr(seed);
			case (wgm[k])
				4'h1: top = 255;
				4'h2: top = 511;
				4'h3: top = 1023;
				default: top = 8 + seed[5:0];
			endcase
			atop = wgm[k] == DSP16_WGM_PC_A || wgm[k] == DSP16_WGM_PFC_A;
			ctop = wgm[k] == DSP16_WGM_PC_C || wgm[k] == DSP16_WGM_PFC_C;
			seed = lfsr(seed);
			ca = 1 + seed[15:0] % (top - 1);
			cb = 1 + seed[31:16] % (top - 1);
			if (k == 7) begin
				ca = 0;
				cb = top;
			end
			ctl = {19'h0, 2'h3, pre[k], DSP16_COM_INV, atop ? DSP16_COM_TGL : DSP16_COM_NON, wgm[k]};
			bus(1'b1, DSP16_OFS_CTRL, ctl & ~32'h700);
			bus(1'b1, DSP16_OFS_CMP_B, 32'hffff);
			bus(1'b0, DSP16_OFS_CMP_B, 32'h0);
			ev = (wgm[k] <= DSP16_WGM_PC10) ? 32'(top) : 32'hffff;
			`CHK(rd, ev)
			bus(1'b1, DSP16_OFS_CAPT, 32'(top));
			bus(1'b1, DSP16_OFS_CMP_A, atop ? 32'(top) : 32'(ca));
			bus(1'b1, DSP16_OFS_CMP_B, 32'(cb));
			bus(1'b1, DSP16_OFS_COUNT, 32'h0);
			bus(1'b1, DSP16_OFS_CTRL, ctl);
			repeat (2 * n * (1024 + top) + 50) @(posedge hclk);
			w = 4 * n * top;
			measure(w);
			`CHK(oa, w)
			`CHK(ob, w)
			`CHK(ha, atop ? w / 2 : 4 * n * ca)
			`CHK(hb, w - 4 * n * cb)
			bus(1'b1, DSP16_OFS_FLAGS, 32'hf);
			repeat (2 * n * top + 20) @(posedge hclk);
			bus(1'b0, DSP16_OFS_FLAGS, 32'h0);
			ev = ctop ? 32'hf : 32'h7;
			`CHK(rd, ev)
		end
		for (j = 0; j < 2; j++) begin
			bus(1'b1, DSP16_OFS_CTRL, j ? 32'h1a1 : 32'h1951);
			repeat (40) @(posedge hclk);
			measure(64);
			`CHK(oa, 0)
			`CHK(ob, 0)
		end
		// Slow dividers: two ticks after two and a half divide periods.
		for (j = 3; j < 6; j++) begin
			n = 64 << (2 * (j - 3));
			bus(1'b1, DSP16_OFS_CTRL, 32'h1);
			bus(1'b1, DSP16_OFS_COUNT, 32'h0);
			bus(1'b1, DSP16_OFS_CTRL, {21'h0, 3'(j), 8'h01});
			repeat (5 * n / 2 - 1) @(posedge hclk);
			bus(1'b0, DSP16_OFS_COUNT, 32'h0);
			`CHK(rd, 32'h2)
		end
		bus(1'b0, 8'h3c, 32'h0);
		`CHK(rd, 32'h0)
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		bus(1'b0, DSP16_OFS_STATUS, 32'h0);
		`CHK(rd, 32'h0)
		bus(1'b0, DSP16_OFS_COUNT, 32'h0);
		`CHK(rd, 32'h0)
		end_sim();
	end
endmodule
